// [ubsc_pkg.sv]
// Package of constants for the utility bus select control block
// Function
// - Buffer enable only for enabled decoded peripherals and floppy DMA acknowledge
// - Enable starts at command falling edge
// - Release at command rise, or at address change for an ISA master
// - DMA: enable follows floppy DMA acknowledge
// - No floppy enable when strap low
// - No enable when DMA acknowledge ignored
// - No enable on status read, IDE off
// - No enable for disabled peripheral decode
// - Reset drives buffer enable high
// - Three-bit select code from the map entry of the decoded hit
// - Reset drives select code all high
// - Bank select low decoder one, high two
// - Clock latch strobe: bank active two ticks
// - Bank select high when idle or reset
// - Bit zero write pulses soft reset low
// - Bit zero must clear before next pulse
// - Reset: soft reset high, bit cleared
// - Address twenty override follows bit one
// - Address twenty override low in reset
// - Status read with IDE off drives inverted disk change
// - Primary or secondary status by setting
// - Disk change strap sampled at reset release
package ubsc_pkg;
   // Register byte addresses
   localparam logic [7:0] UBSC_OFF_PORT92 = 8'h92;
   localparam logic [7:0] UBSC_OFF_ENABLE = 8'h00;
   localparam logic [7:0] UBSC_OFF_MAP = 8'h04;
   localparam logic [7:0] UBSC_OFF_STATUS = 8'h08;
   // Port 92 field positions
   localparam int UBSC_P92_RST_BIT = 0;
   localparam int UBSC_P92_A20_BIT = 1;
   // Enable register field positions
   localparam int UBSC_EN_PERIPH_LSB = 0;
   localparam int UBSC_EN_SECONDARY_BIT = 8;
   localparam int UBSC_EN_IDE_BIT = 9;
   localparam int UBSC_EN_IGN_DACK_BIT = 10;
   // Reset values
   localparam logic [7:0] UBSC_PORT92_RST = 8'h00;
   localparam logic [10:0] UBSC_ENABLE_RST = 11'h000;
   // Peripheral count and index of the floppy and clock entries
   localparam int UBSC_NPERIPH = 8;
   localparam int UBSC_FLOPPY_IDX = 0;
   localparam int UBSC_RTC_IDX = 1;
   // Timing in system clock periods and clock rate
   localparam int UBSC_CLK_MHZ = 125;
   localparam int UBSC_SYSCLK_KHZ = 8333;
   localparam int UBSC_SYSCLK_DIV =
      (UBSC_CLK_MHZ * 1000) / UBSC_SYSCLK_KHZ;
   localparam int UBSC_SOFTRST_SYSCLKS = 4;
   localparam int UBSC_RTC_SYSCLKS = 2;
   // Floppy status locations
   localparam logic [15:0] UBSC_FSTAT_PRI = 16'h03F7;
   localparam logic [15:0] UBSC_FSTAT_SEC = 16'h0377;
   // AXI responses
   localparam logic [1:0] UBSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] UBSC_RESP_SLVERR = 2'h2;
endpackage

// [ubsc_top.sv]
// Utility bus select control: buffer enable, select codes, port 92
`timescale 1ns/1ps
module ubsc_top #(
   parameter int NPERIPH = ubsc_pkg::UBSC_NPERIPH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // PCI reset pin
   input wire logic pci_reset_in_n,
   // ISA commands and address from pins
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic [16:0] sa,
   input wire logic [23:17] la,
   input wire logic isa_master,
   // Peripheral decode hits from the address decoder, one per entry
   input wire logic [NPERIPH-1:0] periph_hit,
   input wire logic rtc_ale_cycle,
   // Floppy DMA and disk change pins
   input wire logic floppy_dma_ack_n,
   input wire logic disk_change_in,
   // Utility bus outputs
   output logic utility_buffer_oe_n,
   output logic [2:0] encoded_select_code,
   output logic decoder_bank_select_n,
   output logic soft_cpu_reset_n,
   output logic addr20_override,
   // System data bit 7 drive, enable low while driving
   output logic sd7_out,
   output logic sd7_oe_n,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ubsc_pkg::*;

   initial begin
      if (NPERIPH < 2 || NPERIPH > 8)
         $error("NPERIPH must lie between 2 and 8");
   end

   typedef enum logic [1:0] {
      UBSC_P_IDLE = 2'b00,
      UBSC_P_LOW = 2'b01,
      UBSC_P_WAIT = 2'b10
   } ubsc_pulse_e;

   // Two-stage synchronisers for every pin input
   localparam int SW = 35;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   assign pin_raw = {pci_reset_in_n, ior_n, iow_n, memr_n, memw_n,
                     sa, la, isa_master, floppy_dma_ack_n,
                     disk_change_in, rtc_ale_cycle, 2'h0};

   // Sync chain; first stage is read only by the second
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= {SW{1'b1}};
         sync2_q <= {SW{1'b1}};
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   // Synchronised views
   logic pci_reset_in_n_n_s, ior_s, iow_s, memr_s, memw_s, ism_s;
   logic dack_s, disk_change_in_s, rtc_s;
   logic [23:0] addr_s;
   assign pci_reset_in_n_n_s = sync2_q[34];
   assign ior_s = ~sync2_q[33];
   assign iow_s = ~sync2_q[32];
   assign memr_s = ~sync2_q[31];
   assign memw_s = ~sync2_q[30];
   logic [16:0] sa_s;
   logic [6:0] la_s;
   assign sa_s = sync2_q[29:13];
   assign la_s = sync2_q[12:6];
   // Full synchronised address, used by the change detector
   assign addr_s = {la_s, sa_s};
   assign ism_s = sync2_q[5];
   assign dack_s = ~sync2_q[4];
   assign disk_change_in_s = sync2_q[3];
   assign rtc_s = sync2_q[2];

   // Reset from the synchronised PCI reset pin only; system reset acts on its own
   logic rst_any;
   assign rst_any = ~pci_reset_in_n_n_s;

   // Registers
   logic [7:0] port92_q;
   logic [10:0] enable_q;
   logic [NPERIPH*4-1:0] map_q;
   logic floppy_present_q;
   logic pci_reset_in_n_seen_q;

   // Strap capture at trailing edge of PCI reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pci_reset_in_n_seen_q <= 1'b0;
         floppy_present_q <= 1'b0;
      end else begin
         pci_reset_in_n_seen_q <= rst_any;
         if (pci_reset_in_n_seen_q && !rst_any)
            floppy_present_q <= disk_change_in_s;
      end
   end

   // Decode qualification per peripheral
   logic [NPERIPH-1:0] hit_ok;
   genvar gi;
   generate
      for (gi = 0; gi < NPERIPH; gi++) begin : g_hit
         // Floppy entry also needs the strap
         if (gi == UBSC_FLOPPY_IDX) begin : g_fl
            assign hit_ok[gi] = periph_hit[gi] & enable_q[gi] &
                                floppy_present_q;
         end else begin : g_ot
            assign hit_ok[gi] = periph_hit[gi] & enable_q[gi];
         end
      end
   endgenerate

   // Floppy status location match
   logic [15:0] fstat_addr;
   logic fstat_read;
   assign fstat_addr = enable_q[UBSC_EN_SECONDARY_BIT] ?
                       UBSC_FSTAT_SEC : UBSC_FSTAT_PRI;
   assign fstat_read = ior_s && sa_s[15:0] == fstat_addr &&
                       floppy_present_q && enable_q[UBSC_FLOPPY_IDX];

   // Priority encode of the selected entry through the map table
   logic any_hit;
   logic [3:0] sel_map;
   always_comb begin
      any_hit = 1'b0;
      sel_map = 4'hF;
      for (int i = NPERIPH - 1; i >= 0; i--) begin
         if (hit_ok[i]) begin
            any_hit = 1'b1;
            sel_map = map_q[i*4 +: 4];
         end
      end
   end

   // Address change detection for ISA master release
   logic [23:0] addr_prev_q;
   logic addr_chg;
   assign addr_chg = addr_prev_q != addr_s;

   // Command state
   logic cmd_act;
   logic cmd_prev_q;
   logic ign_dack;
   logic oe_block;
   assign cmd_act = ior_s | iow_s | memr_s | memw_s;
   assign ign_dack = enable_q[UBSC_EN_IGN_DACK_BIT];
   assign oe_block = ign_dack |
                     (fstat_read & ~enable_q[UBSC_EN_IDE_BIT]);

   // Buffer output enable, active low
   logic oe_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         oe_q <= 1'b0;
         cmd_prev_q <= 1'b0;
         addr_prev_q <= 24'h0;
      end else if (rst_any) begin
         oe_q <= 1'b0;
         cmd_prev_q <= 1'b0;
         addr_prev_q <= 24'h0;
      end else begin
         cmd_prev_q <= cmd_act;
         addr_prev_q <= {la_s, sa_s};
         if (oe_block) begin
            oe_q <= 1'b0;
         end else if (dack_s) begin
            // DMA: follow the acknowledge
            oe_q <= floppy_present_q & enable_q[UBSC_FLOPPY_IDX];
         end else if (cmd_act && !cmd_prev_q && any_hit) begin
            oe_q <= 1'b1;
         end else if (ism_s ? addr_chg : !cmd_act) begin
            oe_q <= 1'b0;
         end
      end
   end
   assign utility_buffer_oe_n = ~oe_q;

   // Divider for system clock ticks
   localparam int DW = 8;
   logic [DW-1:0] div_q;
   logic tick;
   assign tick = div_q == DW'(UBSC_SYSCLK_DIV - 1);
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         div_q <= '0;
      else if (tick)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   // Clock latch strobe stretch of two ticks
   logic [1:0] rtc_cnt_q;
   logic iow_prev_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rtc_cnt_q <= 2'h0;
         iow_prev_q <= 1'b0;
      end else if (rst_any) begin
         rtc_cnt_q <= 2'h0;
         iow_prev_q <= 1'b0;
      end else begin
         iow_prev_q <= iow_s;
         if (rtc_s && iow_s && !iow_prev_q)
            rtc_cnt_q <= 2'(UBSC_RTC_SYSCLKS);
         else if (tick && rtc_cnt_q != 2'h0)
            rtc_cnt_q <= rtc_cnt_q - 1'b1;
      end
   end

   // Select code and bank select registered outputs
   logic [2:0] code_q;
   logic bank_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         code_q <= 3'h7;
         bank_q <= 1'b1;
      end else if (rst_any) begin
         code_q <= 3'h7;
         bank_q <= 1'b1;
      end else if (rtc_cnt_q != 2'h0) begin
         code_q <= map_q[UBSC_RTC_IDX*4 +: 3];
         bank_q <= map_q[UBSC_RTC_IDX*4 + 3];
      end else if (any_hit) begin
         code_q <= sel_map[2:0];
         bank_q <= sel_map[3];
      end else begin
         code_q <= 3'h7;
         bank_q <= 1'b1;
      end
   end
   assign encoded_select_code = code_q;
   assign decoder_bank_select_n = bank_q;

   // Inverted disk change onto data bit 7
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sd7_out <= 1'b0;
         sd7_oe_n <= 1'b1;
      end else begin
         sd7_out <= ~disk_change_in_s;
         // Resident IDE answers the status read itself, so stay off
         sd7_oe_n <= ~(fstat_read & ~enable_q[UBSC_EN_IDE_BIT] &
                       ~rst_any);
      end
   end

   // Soft reset pulse state machine
   ubsc_pulse_e pst_q;
   logic [7:0] pcnt_q;
   localparam int PULSE_CYC = UBSC_SOFTRST_SYSCLKS * UBSC_SYSCLK_DIV;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pst_q <= UBSC_P_IDLE;
         pcnt_q <= 8'h00;
      end else if (rst_any) begin
         pst_q <= UBSC_P_IDLE;
         pcnt_q <= 8'h00;
      end else begin
         unique case (pst_q)
            UBSC_P_IDLE: begin
               if (port92_q[UBSC_P92_RST_BIT]) begin
                  pst_q <= UBSC_P_LOW;
                  pcnt_q <= 8'(PULSE_CYC - 1);
               end
            end
            UBSC_P_LOW: begin
               if (pcnt_q == 8'h00)
                  pst_q <= UBSC_P_WAIT;
               else
                  pcnt_q <= pcnt_q - 1'b1;
            end
            UBSC_P_WAIT: begin
               if (!port92_q[UBSC_P92_RST_BIT])
                  pst_q <= UBSC_P_IDLE;
            end
            default: pst_q <= UBSC_P_IDLE;
         endcase
      end
   end
   assign soft_cpu_reset_n = pst_q != UBSC_P_LOW;
   assign addr20_override = port92_q[UBSC_P92_A20_BIT];

   // AXI write channel capture
   logic aw_q, w_q, bv_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready = !w_q && !bv_q;
   assign s_axi_bvalid = bv_q;
   logic wr_go;
   assign wr_go = aw_q && w_q && !bv_q;
   logic wr_hit;
   assign wr_hit = awaddr_q == UBSC_OFF_PORT92 ||
                   awaddr_q == UBSC_OFF_ENABLE ||
                   awaddr_q == UBSC_OFF_MAP;

   // Write handshake, accepts address and data in either order
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_bresp <= UBSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b1;
            s_axi_bresp <= wr_hit ? UBSC_RESP_OKAY : UBSC_RESP_SLVERR;
         end else if (bv_q && s_axi_bready) begin
            bv_q <= 1'b0;
         end
      end
   end

   // Register storage; PCI reset clears port 92
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         port92_q <= UBSC_PORT92_RST;
         enable_q <= UBSC_ENABLE_RST;
         map_q <= '1;
      end else if (rst_any) begin
         port92_q <= UBSC_PORT92_RST;
         enable_q <= UBSC_ENABLE_RST;
         map_q <= '1;
      end else if (wr_go) begin
         if (awaddr_q == UBSC_OFF_PORT92 && wstrb_q[0])
            port92_q <= wdata_q[7:0];
         if (awaddr_q == UBSC_OFF_ENABLE) begin
            if (wstrb_q[0])
               enable_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1])
               enable_q[10:8] <= wdata_q[10:8];
         end
         if (awaddr_q == UBSC_OFF_MAP) begin
            for (int b = 0; b < NPERIPH / 2; b++) begin
               if (wstrb_q[b])
                  map_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            end
         end
      end
   end

   // Read channel: one-cycle answer, held until rready
   logic rv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid = rv_q;
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0;
      unique case (s_axi_araddr)
         UBSC_OFF_PORT92: rmux = {24'h0, port92_q};
         UBSC_OFF_ENABLE: rmux = {21'h0, enable_q};
         UBSC_OFF_MAP: rmux = 32'(map_q);
         UBSC_OFF_STATUS: rmux = {27'h0, floppy_present_q, oe_q,
                                  pst_q == UBSC_P_WAIT,
                                  pst_q == UBSC_P_LOW, disk_change_in_s};
         default: rmux = 32'h0;
      endcase
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rv_q <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= UBSC_RESP_OKAY;
      end else if (s_axi_arvalid && !rv_q) begin
         rv_q <= 1'b1;
         s_axi_rdata <= rmux;
         s_axi_rresp <= (s_axi_araddr == UBSC_OFF_PORT92 ||
                         s_axi_araddr == UBSC_OFF_ENABLE ||
                         s_axi_araddr == UBSC_OFF_MAP ||
                         s_axi_araddr == UBSC_OFF_STATUS) ?
                        UBSC_RESP_OKAY : UBSC_RESP_SLVERR;
      end else if (rv_q && s_axi_rready) begin
         rv_q <= 1'b0;
      end
   end

   // Padding bits of the synchroniser bundle are never read
   logic unused_ok;
   assign unused_ok = ^sync2_q[1:0];
endmodule

// [ubsc_top_properties.sv]
// Port-level assertions for the utility bus select control block
`timescale 1ns/1ps
module ubsc_top_properties #(
   parameter int NPERIPH = 8
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic pci_reset_in_n,
   // Commands and decode
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic [NPERIPH-1:0] periph_hit,
   input wire logic rtc_ale_cycle,
   input wire logic floppy_dma_ack_n,
   input wire logic disk_change_in,
   // Outputs under watch
   input wire logic utility_buffer_oe_n,
   input wire logic decoder_bank_select_n,
   input wire logic soft_cpu_reset_n,
   input wire logic addr20_override,
   input wire logic sd7_out,
   input wire logic sd7_oe_n,
   input wire logic s_axi_bvalid
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Any command or DMA acknowledge active
   wire cmd_act = !ior_n || !iow_n || !memr_n || !memw_n || !floppy_dma_ack_n;
   // Cycles since the last command, saturating so it never wraps
   logic [3:0] idle_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         idle_q <= 4'hF;
      end else if (cmd_act) begin
         idle_q <= 4'h0;
      end else if (idle_q != 4'hF) begin
         idle_q <= idle_q + 4'h1;
      end
   end
   property p_oe_cause;
      $fell(utility_buffer_oe_n) |-> idle_q < 4'h6;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("oe no cmd");
   property p_oe_release;
      idle_q == 4'h8 |-> utility_buffer_oe_n;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("oe held");
   property p_rst_oe;
      !pci_reset_in_n [*4] |=> utility_buffer_oe_n;
   endproperty
   a_rst_oe: assert property (p_rst_oe) else $error("oe in reset");
   property p_rst_bank;
      !pci_reset_in_n [*4] |=> decoder_bank_select_n;
   endproperty
   a_rst_bank: assert property (p_rst_bank) else $error("bank rst");
   property p_rst_a20;
      !pci_reset_in_n [*4] |=> !addr20_override && soft_cpu_reset_n;
   endproperty
   a_rst_a20: assert property (p_rst_a20) else $error("a20 rst");
   property p_soft_pulse;
      $fell(soft_cpu_reset_n) |-> !soft_cpu_reset_n [*8];
   endproperty
   a_soft_pulse: assert property (p_soft_pulse) else $error("short");
   property p_rtc_hold;
      $fell(decoder_bank_select_n) && rtc_ale_cycle
         |-> !decoder_bank_select_n [*8];
   endproperty
   a_rtc_hold: assert property (p_rtc_hold) else $error("rtc bank");
   property p_a20_write;
      $rose(addr20_override)
         |-> (s_axi_bvalid || $past(s_axi_bvalid)) or (##1 s_axi_bvalid);
   endproperty
   a_a20_write: assert property (p_a20_write) else $error("a20 rose");
   property p_sd7_val;
      !sd7_oe_n |-> sd7_out == !disk_change_in;
   endproperty
   a_sd7_val: assert property (p_sd7_val) else $error("sd7 value");
   // Main scenarios reached
   c_oe: cover property ($fell(utility_buffer_oe_n));
   c_pulse: cover property ($fell(soft_cpu_reset_n));
   c_sd7: cover property ($fell(sd7_oe_n));
endmodule

// [ubsc_periph_model.sv]
// Model of the two external decoders on the utility bus
`timescale 1ns/1ps
module ubsc_periph_model (
   // Select lines from the block
   input wire logic [2:0] encoded_select_code,
   input wire logic decoder_bank_select_n,
   input wire logic utility_buffer_oe_n,
   // Decoder one in 7:0, decoder two in 15:8, low active
   output logic [15:0] periph_sel_n
);
   logic [3:0] idx;
   assign idx = {decoder_bank_select_n, encoded_select_code};
   // Selects only while the buffer is on, so stale codes select nothing
   always_comb begin
      periph_sel_n = 16'hFFFF;
      if (!utility_buffer_oe_n) begin
         periph_sel_n[idx] = 1'b0;
      end
   end
endmodule

// [tb.sv]
// Self-checking bench for the utility bus select control block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
   import ubsc_pkg::*;
   // Soft reset pulse length in fast clocks
   localparam int PULSE = UBSC_SOFTRST_SYSCLKS * UBSC_SYSCLK_DIV;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic pci_reset_in_n = 1'b0;
   logic [4:0] cmd_n = 5'h1F; // ior, iow, memr, memw, floppy dack
   logic [16:0] sa = '0;
   logic [23:17] la = '0;
   logic isa_master = 1'b0;
   logic rtc_ale_cycle = 1'b0;
   logic [7:0] periph_hit = '0;
   logic disk_change_in = 1'b1; // Strap high: floppy present
   // Block outputs and model selects
   logic utility_buffer_oe_n, decoder_bank_select_n, soft_cpu_reset_n;
   logic addr20_override, sd7_out, sd7_oe_n;
   logic [2:0] encoded_select_code, code_s;
   logic [15:0] periph_sel_n, sel_s;
   logic oe_s, bank_s, sd7oe_s, sd7_s; // Late snapshot of a cycle
   // Register bus
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [73:0] rows [4]; // Address, write data, read back, response
   int n_errors = 0;
   int total_checks = 0;
   int lows = 0;
   int base;
   always #4 clk_sys = ~clk_sys;
   // Count clocks with soft reset low
   always @(posedge clk_sys) begin
      if (soft_cpu_reset_n === 1'b0) begin
         lows++;
      end
   end
   ubsc_top #(.NPERIPH(8)) dut (
      .clk_sys, .sys_rst, .pci_reset_in_n,
      .ior_n(cmd_n[0]), .iow_n(cmd_n[1]), .memr_n(cmd_n[2]),
      .memw_n(cmd_n[3]), .floppy_dma_ack_n(cmd_n[4]),
      .sa, .la, .isa_master, .periph_hit, .rtc_ale_cycle, .disk_change_in,
      .utility_buffer_oe_n, .encoded_select_code, .decoder_bank_select_n,
      .soft_cpu_reset_n, .addr20_override, .sd7_out, .sd7_oe_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready
   );
   ubsc_periph_model model (
      .encoded_select_code, .decoder_bank_select_n, .utility_buffer_oe_n,
      .periph_sel_n
   );
   // Write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         t++;
      end while (s_axi_bvalid !== 1'b1 && t < 40);
      `CHK(s_axi_bvalid, 1'b1)
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Read: address dropped when taken, rready held high until rvalid is seen
   task automatic axi_rd(input logic [7:0] a);
      int t;
      t = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         t++;
      end while (s_axi_rvalid !== 1'b1 && t < 40);
      `CHK(s_axi_rvalid, 1'b1)
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Command cycle: the two-stage input sync needs the long hold
   task automatic isa_cyc(input int c, input logic [16:0] a,
                          input logic [7:0] h);
      sa <= a;
      periph_hit <= h;
      cmd_n[c] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      oe_s = utility_buffer_oe_n;
      code_s = encoded_select_code;
      bank_s = decoder_bank_select_n;
      sd7oe_s = sd7_oe_n;
      sd7_s = sd7_out;
      sel_s = periph_sel_n;
      cmd_n <= 5'h1F;
      periph_hit <= '0;
      repeat (8) @(posedge clk_sys);
      `CHK(utility_buffer_oe_n, 1'b1)
   endtask
   // Idle output levels while PCI reset is held
   task automatic pci_pulse();
      pci_reset_in_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      `CHK(utility_buffer_oe_n, 1'b1)
      `CHK(encoded_select_code, 3'h7)
      `CHK(decoder_bank_select_n, 1'b1)
      `CHK(soft_cpu_reset_n, 1'b1)
      `CHK(addr20_override, 1'b0)
      pci_reset_in_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
   endtask
   // Write port 92, then count soft reset low clocks over a fixed span
   task automatic pulse_chk(input logic [31:0] d, input int e);
      base = lows;
      axi_wr(UBSC_OFF_PORT92, d);
      repeat (100) @(posedge clk_sys);
      `CHK((lows - base) inside {[e - 1:e + 1]}, 1'b1)
   endtask
   task automatic finish_test();
      if (n_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard: the tests need well under a tenth of this span
   initial begin
      #100us;
      n_errors++;
      finish_test();
   end
   initial begin
      rows[0] = {UBSC_OFF_MAP, 32'h19, 32'h19, UBSC_RESP_OKAY};
      rows[1] = {UBSC_OFF_ENABLE, 32'h3, 32'h3, UBSC_RESP_OKAY};
      rows[2] = {UBSC_OFF_PORT92, 32'h2, 32'h2, UBSC_RESP_OKAY};
      rows[3] = {8'h40, 32'h5A, 32'h0, UBSC_RESP_SLVERR};
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      pci_pulse();
      axi_rd(UBSC_OFF_PORT92);
      `CHK(rd, 32'h0)
      axi_rd(UBSC_OFF_MAP);
      `CHK(rd, 32'hFFFFFFFF)
      foreach (rows[i]) begin
         axi_wr(rows[i][73:66], rows[i][65:34]);
         `CHK(resp, rows[i][1:0])
         axi_rd(rows[i][73:66]);
         `CHK(resp, rows[i][1:0])
         `CHK(rd, rows[i][33:2])
      end
      `CHK(addr20_override, 1'b1)
      // Floppy under each command: decoder two, code one
      for (int c = 0; c < 4; c++) begin
         isa_cyc(c, 17'h003F2, 8'h01);
         `CHK(oe_s, 1'b0)
         `CHK(code_s, 3'h1)
         `CHK(sel_s, 16'hFDFF)
      end
      // Clock latch write on decoder one
      rtc_ale_cycle <= 1'b1;
      isa_cyc(1, 17'h00070, 8'h02);
      `CHK(bank_s, 1'b0)
      `CHK(sel_s, 16'hFFFD)
      rtc_ale_cycle <= 1'b0;
      isa_cyc(1, 17'h00060, 8'h04);
      `CHK(oe_s, 1'b1)
      // Status reads: inverted disk change on bit 7, buffer off unless IDE set
      disk_change_in <= 1'b0;
      isa_cyc(0, 17'h003F7, 8'h01);
      `CHK(oe_s, 1'b1)
      `CHK(sd7_s, 1'b1)
      axi_wr(UBSC_OFF_ENABLE, 32'h103);
      isa_cyc(0, 17'h00377, 8'h01);
      `CHK(sd7oe_s, 1'b0)
      axi_wr(UBSC_OFF_ENABLE, 32'h203);
      isa_cyc(0, 17'h003F7, 8'h01);
      `CHK(oe_s, 1'b0)
      `CHK(sd7oe_s, 1'b1)
      // Floppy DMA, then with the acknowledge ignored
      axi_wr(UBSC_OFF_ENABLE, 32'h3);
      isa_cyc(4, 17'h0, 8'h00);
      `CHK(oe_s, 1'b0)
      axi_wr(UBSC_OFF_ENABLE, 32'h403);
      isa_cyc(4, 17'h0, 8'h00);
      `CHK(oe_s, 1'b1)
      // Pulse once, blocked while bit 0 stays set, again after clearing
      pulse_chk(32'h3, PULSE);
      pulse_chk(32'h3, 0);
      pulse_chk(32'h2, 0);
      pulse_chk(32'h3, PULSE);
      // Mid-run PCI reset with the strap low: floppy left unserved
      pci_pulse();
      axi_rd(UBSC_OFF_PORT92);
      `CHK(rd, 32'h0)
      axi_wr(UBSC_OFF_MAP, 32'h19);
      axi_wr(UBSC_OFF_ENABLE, 32'h3);
      isa_cyc(1, 17'h003F2, 8'h01);
      `CHK(oe_s, 1'b1)
      isa_cyc(0, 17'h003F7, 8'h01);
      `CHK(sd7oe_s, 1'b1)
      isa_cyc(4, 17'h0, 8'h00);
      `CHK(oe_s, 1'b1)
      finish_test();
   end
endmodule
bind ubsc_top ubsc_top_properties #(.NPERIPH(NPERIPH)) u_props (
   .clk_sys, .sys_rst, .pci_reset_in_n, .ior_n, .iow_n, .memr_n, .memw_n,
   .periph_hit, .rtc_ale_cycle, .floppy_dma_ack_n, .disk_change_in,
   .utility_buffer_oe_n, .decoder_bank_select_n, .soft_cpu_reset_n,
   .addr20_override, .sd7_out, .sd7_oe_n, .s_axi_bvalid
);
